// ### pkg/acw_pkg.sv
// Purpose: Shared constants and types for the converter control block
// Assumes: AXI4-Lite, 32-bit data, one aligned word per 8-bit register
// Notes:   Register data sits in bits 7:0, upper bits read as zero
package acw_pkg;

  // Byte addresses
  localparam logic [7:0] A_CTL  = 8'h00;
  localparam logic [7:0] A_OFS  = 8'h04;
  localparam logic [7:0] A_RHI  = 8'h08;
  localparam logic [7:0] A_RNIB = 8'h0c;
  localparam logic [7:0] A_RLO  = 8'h10;
  localparam logic [7:0] A_STAT = 8'h14;
  localparam logic [7:0] A_MASK = 8'h18;

  // Control register fields
  localparam int CTL_REF  = 7;
  localparam int CTL_RATE = 5;
  localparam int CTL_RUN  = 4;
  localparam int CTL_PWR  = 3;
  localparam int CTL_CH   = 0;

  // Offset register fields
  localparam int OFS_CAL  = 7;
  localparam int OFS_SIGN = 6;
  localparam int OFS_MAG  = 3;
  localparam int OFS_LVL  = 1;
  localparam int OFS_INT  = 0;

  // Status and wake register fields
  localparam int ST_LVDN = 7;
  localparam int ST_LVF  = 6;
  localparam int ST_CDF  = 5;
  localparam int ST_CMF  = 4;
  localparam int ST_WAKE = 0;

  // Reset values
  localparam logic [7:0] CTL_RST  = 8'h00;
  localparam logic [7:0] OFS_RST  = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic       LVDN_RST = 1'b1;

  // Converter clock half periods in MCLK cycles, per rate code
  localparam logic [3:0] HALF_R0 = 4'h8;
  localparam logic [3:0] HALF_R1 = 4'h4;
  localparam logic [3:0] HALF_R2 = 4'h2;
  localparam logic [3:0] HALF_R3 = 4'h1;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [11:0] RES_MAX    = 12'hfff;

  // Drive bundle towards the analog converter macro
  typedef struct packed {
    logic       start;
    logic       power;
    logic       ref_ext;
    logic       int_ref_on;
    logic [1:0] int_ref_lvl;
    logic [3:0] chan;
  } acw_conv_t;

  // Shared reference / timer input / port pin function
  typedef struct packed {
    logic is_ref;
    logic is_timer;
    logic is_port;
  } acw_pin_t;

endpackage

// ### hdl/acw_sync.sv
// Purpose: Three-stage synchroniser for pin inputs
// Assumes: Inputs are asynchronous levels
// Notes:   Output follows only once stages two and three agree
`timescale 1ns/1ps
module acw_sync #(
  parameter int W = 2
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] o;
  } acw_sync_st_t;

  acw_sync_st_t q;
  acw_sync_st_t d;

  always_comb begin
    d    = q;
    d.s1 = din;
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < W; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.o[i] = q.s3[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign dout = q.o;

endmodule

// ### hdl/acw_clkdiv.sv
// Purpose: Converter clock generator from MCLK
// Assumes: Rate code 00 divides by 16
// Notes:   Held low while the converter is powered down
`timescale 1ns/1ps
module acw_clkdiv (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       en,
  input  wire logic [1:0] rate,
  output logic            clk_out
);

  typedef struct packed {
    logic [3:0] cnt;
    logic       ck;
  } acw_div_st_t;

  acw_div_st_t q;
  acw_div_st_t d;
  logic [3:0]  half;

  always_comb begin
    case (rate)
      2'h0:    half = acw_pkg::HALF_R0;
      2'h1:    half = acw_pkg::HALF_R1;
      2'h2:    half = acw_pkg::HALF_R2;
      default: half = acw_pkg::HALF_R3;
    endcase
    d = q;
    if (!en) begin
      d = '0;
    end else if (q.cnt >= half - 4'h1) begin
      d.cnt = 4'h0;
      d.ck  = ~q.ck;
    end else begin
      d.cnt = q.cnt + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign clk_out = q.ck;

endmodule

// ### hdl/acw_top.sv
// Purpose: Converter control, result and wake-flag registers over AXI4-Lite
// Assumes: Analog macro and pin logic run on MCLK; pins CMP_OUT, LVD_LOW async
// Notes:   Offset calibration is applied digitally to the raw result
// How it works
// - Control bit 7 picks supply (0) or external reference pin (1).
// - Shared pin priority: reference, then timer input, then port bit.
// - Clock-rate field 00 runs converter at one sixteenth of MCLK.
// - Writing 1 to run starts conversion; only hardware clears it.
// - Power bit 0 holds converter powered down, 1 lets it run.
// - Channel select picks inputs 0..7, or op-amp / quarter supply.
// - Channel select changes only while done flag and run are low.
// - Offset bit 7 enables calibration, bit 6 gives polarity.
// - Offset magnitude field applies twice its value in LSBs.
// - Reference level field selects level; nonzero turns reference on.
// - Offset bit 0 routes internal channels to converter input.
// - Completion loads result, clears run, sets done flag together.
// - Result reads as bits 11..4, nibble 11..8, and bits 7..0.
// - Status flags set only by hardware; software may only clear.
// - Status read returns stored contents ANDed with mask register.
// - Bit 7 reads 0 while supply low, else 1.
// - Comparator change and conversion end set flags until cleared.
// - Wake enables let each event wake the CPU; all reset 0.
//
// The AXI4-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
module acw_top (
  input  wire logic               MCLK,
  input  wire logic               RST_B,
  input  wire logic [7:0]         S_AXI_AWADDR,
  input  wire logic               S_AXI_AWVALID,
  output logic                    S_AXI_AWREADY,
  input  wire logic [31:0]        S_AXI_WDATA,
  input  wire logic [3:0]         S_AXI_WSTRB,
  input  wire logic               S_AXI_WVALID,
  output logic                    S_AXI_WREADY,
  output logic [1:0]              S_AXI_BRESP,
  output logic                    S_AXI_BVALID,
  input  wire logic               S_AXI_BREADY,
  input  wire logic [7:0]         S_AXI_ARADDR,
  input  wire logic               S_AXI_ARVALID,
  output logic                    S_AXI_ARREADY,
  output logic [31:0]             S_AXI_RDATA,
  output logic [1:0]              S_AXI_RRESP,
  output logic                    S_AXI_RVALID,
  input  wire logic               S_AXI_RREADY,
  input  wire logic               CONV_DONE,
  input  wire logic [11:0]        CONV_DATA,
  input  wire logic               CMP_OUT,
  input  wire logic               LVD_LOW,
  input  wire logic               PORT_CHANGE,
  input  wire logic               TIMER_SOURCE_SEL,
  output acw_pkg::acw_conv_t      CONV,
  output logic                    CONV_CLK,
  output acw_pkg::acw_pin_t       SHARED_PIN,
  output logic                    CONV_DONE_FLAG,
  output logic                    COMPARATOR_FLAG,
  output logic                    LOW_VOLT_FLAG,
  output logic                    WAKE_REQ
);

  typedef struct packed {
    // Converter control
    logic        ref_source_sel;
    logic [1:0]  conv_clk_rate;
    logic        conv_run;
    logic        conv_power;
    logic [2:0]  chan_sel;
    // Offset calibration
    logic        offset_cal_en;
    logic        offset_sign;
    logic [2:0]  offset_magnitude;
    logic [1:0]  int_ref_level;
    logic        internal_chan_en;
    // Results and flags
    logic [11:0] result;
    logic        low_volt_state_n;
    logic        low_volt_flag;
    logic        conv_done_flag;
    logic        comparator_flag;
    logic [3:0]  wake_en;
    logic [7:0]  irq_mask;
    logic        busy;
    logic        cmp_prev;
    // Registered outputs
    acw_pkg::acw_conv_t conv;
    acw_pkg::acw_pin_t  pin;
    logic        wake_req;
    // Bus slave
    logic        aw_got;
    logic        w_got;
    logic [7:0]  waddr;
    logic [7:0]  wdata;
    logic        wlane0;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
  } acw_state_t;

  acw_state_t  q;
  acw_state_t  d;
  logic [1:0]  pin_s;
  logic        cmp_s;
  logic        lvd_n_s;
  logic [12:0] adj;
  logic [12:0] offs;
  logic [7:0]  status;
  logic [7:0]  rd_byte;
  logic        rd_hit;
  logic        wr_go;

  acw_sync #(
    .W(2)
  ) u_sync (
    .clk   (MCLK),
    .rst_b (RST_B),
    .din   ({CMP_OUT, LVD_LOW}),
    .dout  (pin_s)
  );

  // Converter clock stops while powered down to save the analog current
  acw_clkdiv u_div (
    .clk     (MCLK),
    .rst_b   (RST_B),
    .en      (q.conv_power),
    .rate    (q.conv_clk_rate),
    .clk_out (CONV_CLK)
  );

  assign cmp_s   = pin_s[1];
  assign lvd_n_s = ~pin_s[0];

  // Offset correction saturates rather than wrapping at the range ends
  always_comb begin
    offs = {9'h000, q.offset_magnitude, 1'b0};
    adj  = {1'b0, CONV_DATA};
    if (q.offset_cal_en) begin
      if (q.offset_sign) begin
        adj = adj + offs;
        if (adj[12]) begin
          adj = {1'b0, acw_pkg::RES_MAX};
        end
      end else if (adj < offs) begin
        adj = 13'h0000;
      end else begin
        adj = adj - offs;
      end
    end
  end

  // Masked view of status and wake register
  always_comb begin
    status = {q.low_volt_state_n, q.low_volt_flag, q.conv_done_flag,
              q.comparator_flag, q.wake_en} & q.irq_mask;
  end

  always_comb begin
    rd_hit  = 1'b1;
    rd_byte = 8'h00;
    case (S_AXI_ARADDR)
      acw_pkg::A_CTL:  rd_byte = {q.ref_source_sel, q.conv_clk_rate, q.conv_run,
                                  q.conv_power, q.chan_sel};
      acw_pkg::A_OFS:  rd_byte = {q.offset_cal_en, q.offset_sign, q.offset_magnitude,
                                  q.int_ref_level, q.internal_chan_en};
      acw_pkg::A_RHI:  rd_byte = q.result[11:4];
      acw_pkg::A_RNIB: rd_byte = {4'h0, q.result[11:8]};
      acw_pkg::A_RLO:  rd_byte = q.result[7:0];
      acw_pkg::A_STAT: rd_byte = status;
      acw_pkg::A_MASK: rd_byte = q.irq_mask;
      default:         rd_hit  = 1'b0;
    endcase
  end

  always_comb begin
    d       = q;
    wr_go   = q.aw_got & q.w_got & ~q.bvalid;
    d.conv.start = 1'b0;

    // Write address and data may arrive in either order
    if (S_AXI_AWVALID && q.awready) begin
      d.aw_got = 1'b1;
      d.waddr  = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && q.wready) begin
      d.w_got  = 1'b1;
      d.wdata  = S_AXI_WDATA[7:0];
      d.wlane0 = S_AXI_WSTRB[0];
    end
    if (q.bvalid && S_AXI_BREADY) begin
      d.bvalid = 1'b0;
    end

    if (wr_go) begin
      d.aw_got = 1'b0;
      d.w_got  = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = acw_pkg::RESP_OKAY;
      case (q.waddr)
        acw_pkg::A_CTL: begin
          if (q.wlane0) begin
            d.ref_source_sel = q.wdata[acw_pkg::CTL_REF];
            d.conv_clk_rate  = q.wdata[acw_pkg::CTL_RATE +: 2];
            d.conv_power     = q.wdata[acw_pkg::CTL_PWR];
            // A written 0 on run is ignored
            if (q.wdata[acw_pkg::CTL_RUN]) begin
              d.conv_run = 1'b1;
            end
            if (!q.conv_done_flag && !q.conv_run) begin
              d.chan_sel = q.wdata[acw_pkg::CTL_CH +: 3];
            end
          end
        end
        acw_pkg::A_OFS: begin
          if (q.wlane0) begin
            d.offset_cal_en    = q.wdata[acw_pkg::OFS_CAL];
            d.offset_sign      = q.wdata[acw_pkg::OFS_SIGN];
            d.offset_magnitude = q.wdata[acw_pkg::OFS_MAG +: 3];
            d.int_ref_level    = q.wdata[acw_pkg::OFS_LVL +: 2];
            d.internal_chan_en = q.wdata[acw_pkg::OFS_INT];
          end
        end
        acw_pkg::A_STAT: begin
          if (q.wlane0) begin
            // Flags clear on a written 0, a written 1 leaves them alone
            d.low_volt_flag   = q.low_volt_flag & q.wdata[acw_pkg::ST_LVF];
            d.conv_done_flag  = q.conv_done_flag & q.wdata[acw_pkg::ST_CDF];
            d.comparator_flag = q.comparator_flag & q.wdata[acw_pkg::ST_CMF];
            d.wake_en         = q.wdata[acw_pkg::ST_WAKE +: 4];
          end
        end
        acw_pkg::A_MASK: begin
          if (q.wlane0) begin
            d.irq_mask = q.wdata;
          end
        end
        acw_pkg::A_RHI, acw_pkg::A_RNIB, acw_pkg::A_RLO: begin
          d.bresp = acw_pkg::RESP_OKAY;
        end
        default: d.bresp = acw_pkg::RESP_SLVERR;
      endcase
    end

    d.awready = ~d.aw_got & ~d.bvalid;
    d.wready  = ~d.w_got & ~d.bvalid;

    // Read channel, one outstanding read
    if (q.rvalid && S_AXI_RREADY) begin
      d.rvalid = 1'b0;
    end
    if (S_AXI_ARVALID && q.arready) begin
      d.rvalid = 1'b1;
      d.rdata  = {24'h000000, rd_byte};
      d.rresp  = rd_hit ? acw_pkg::RESP_OKAY : acw_pkg::RESP_SLVERR;
    end
    d.arready = ~d.rvalid;

    // Run waits for power before the macro sees a start
    if (q.conv_run && q.conv_power && !q.busy) begin
      d.busy       = 1'b1;
      d.conv.start = 1'b1;
    end

    // Hardware events applied last so a set beats a same-cycle clear
    if (q.busy && CONV_DONE) begin
      d.result         = adj[11:0];
      d.conv_run       = 1'b0;
      d.busy           = 1'b0;
      d.conv_done_flag = 1'b1;
    end
    d.cmp_prev = cmp_s;
    if (cmp_s != q.cmp_prev) begin
      d.comparator_flag = 1'b1;
    end
    d.low_volt_state_n = lvd_n_s;
    if (lvd_n_s != q.low_volt_state_n) begin
      d.low_volt_flag = 1'b1;
    end

    // Registered converter and pin drives
    d.conv.power       = d.conv_power;
    d.conv.ref_ext     = d.ref_source_sel;
    d.conv.int_ref_lvl = d.int_ref_level;
    d.conv.int_ref_on  = |d.int_ref_level;
    if (d.internal_chan_en) begin
      d.conv.chan = {1'b1, d.chan_sel[2], 2'h0};
    end else begin
      d.conv.chan = {1'b0, d.chan_sel};
    end
    d.pin.is_ref   = d.ref_source_sel;
    d.pin.is_timer = ~d.ref_source_sel & TIMER_SOURCE_SEL;
    d.pin.is_port  = ~d.ref_source_sel & ~TIMER_SOURCE_SEL;

    d.wake_req = (d.conv_done_flag & d.wake_en[3]) |
                 (d.comparator_flag & d.wake_en[2]) |
                 (PORT_CHANGE & d.wake_en[1]) |
                 (d.low_volt_flag & d.wake_en[0]);
  end

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      q                  <= '0;
      q.ref_source_sel   <= acw_pkg::CTL_RST[acw_pkg::CTL_REF];
      q.conv_power       <= acw_pkg::CTL_RST[acw_pkg::CTL_PWR];
      q.offset_cal_en    <= acw_pkg::OFS_RST[acw_pkg::OFS_CAL];
      q.internal_chan_en <= acw_pkg::OFS_RST[acw_pkg::OFS_INT];
      q.irq_mask         <= acw_pkg::MASK_RST;
      q.low_volt_state_n <= acw_pkg::LVDN_RST;
    end else begin
      q <= d;
    end
  end

  assign S_AXI_AWREADY   = q.awready;
  assign S_AXI_WREADY    = q.wready;
  assign S_AXI_BRESP     = q.bresp;
  assign S_AXI_BVALID    = q.bvalid;
  assign S_AXI_ARREADY   = q.arready;
  assign S_AXI_RDATA     = q.rdata;
  assign S_AXI_RRESP     = q.rresp;
  assign S_AXI_RVALID    = q.rvalid;
  assign CONV            = q.conv;
  assign SHARED_PIN      = q.pin;
  assign CONV_DONE_FLAG  = q.conv_done_flag;
  assign COMPARATOR_FLAG = q.comparator_flag;
  assign LOW_VOLT_FLAG   = q.low_volt_flag;
  assign WAKE_REQ        = q.wake_req;

endmodule

// ### bench/acw_top_props.sv
// Purpose: Port-level assertions for the converter control block
// Assumes: One MCLK domain, RST_B asynchronous and active low
// Notes:   Bound to acw_top from the bench top file
`timescale 1ns/1ps
module acw_props (
  input wire logic               MCLK,
  input wire logic               RST_B,
  input wire logic               S_AXI_ARVALID,
  input wire logic               S_AXI_ARREADY,
  input wire logic               S_AXI_RVALID,
  input wire logic               S_AXI_BVALID,
  input wire logic               S_AXI_BREADY,
  input wire logic               CONV_DONE,
  input wire logic               PORT_CHANGE,
  input wire logic               TIMER_SOURCE_SEL,
  input wire acw_pkg::acw_conv_t CONV,
  input wire logic               CONV_CLK,
  input wire acw_pkg::acw_pin_t  SHARED_PIN,
  input wire logic               CONV_DONE_FLAG,
  input wire logic               COMPARATOR_FLAG,
  input wire logic               LOW_VOLT_FLAG,
  input wire logic               WAKE_REQ
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_B);

  a_start_one_pulse: assert property (CONV.start |=> !CONV.start)
    else $error("start pulse longer than one cycle");
  a_start_needs_power: assert property (CONV.start |-> CONV.power)
    else $error("start while powered down");
  a_clk_held_down: assert property (!CONV.power [*3] |-> !CONV_CLK)
    else $error("converter clock runs while powered down");
  a_done_has_cause: assert property ($rose(CONV_DONE_FLAG) |-> $past(CONV_DONE))
    else $error("done flag set without completion");
  a_chan_frozen: assert property (CONV_DONE_FLAG |=> $stable(CONV.chan))
    else $error("channel changed while done flag high");
  a_chan_legal: assert property (CONV.chan[3] |-> CONV.chan[1:0] == 2'b00)
    else $error("illegal internal channel code");
  a_ref_on_level: assert property (CONV.int_ref_on == (CONV.int_ref_lvl != 2'b00))
    else $error("reference enable does not follow level");
  a_pin_one_func: assert property ($past(RST_B) |-> $onehot(SHARED_PIN))
    else $error("shared pin function not unique");
  a_timer_needs_sel: assert property (SHARED_PIN.is_timer |-> $past(TIMER_SOURCE_SEL))
    else $error("timer function without select");
  // Flags and wake request load at the same edge, so the flags are seen now
  a_wake_has_cause: assert property ($rose(WAKE_REQ) |-> $past(PORT_CHANGE)
    || CONV_DONE_FLAG || COMPARATOR_FLAG || LOW_VOLT_FLAG)
    else $error("wake request without event");
  a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read answer late");
  a_resp_once: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
    else $error("write response repeated");

  c_start: cover property (CONV.start);
  c_done: cover property ($rose(CONV_DONE_FLAG));
  c_wake: cover property ($rose(WAKE_REQ));
endmodule

// ### bench/acw_top_tb_top.sv
// Purpose: Self-checking bench for the converter control block
// Assumes: AXI4-Lite master tasks, converter macro played by the bench
// Notes:   Waits are bounded; a stuck handshake counts as a mismatch
`timescale 1ns/1ps
module acw_top_tb_top;
  logic MCLK, RST_B, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
  logic S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic S_AXI_RREADY, CONV_DONE, CMP_OUT, LVD_LOW, PORT_CHANGE, TIMER_SOURCE_SEL;
  logic CONV_CLK, CONV_DONE_FLAG, COMPARATOR_FLAG, LOW_VOLT_FLAG, WAKE_REQ;
  logic [7:0]         S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0]        S_AXI_WDATA, S_AXI_RDATA, rv;
  logic [3:0]         S_AXI_WSTRB;
  logic [1:0]         S_AXI_BRESP, S_AXI_RRESP, rr;
  logic [11:0]        CONV_DATA;
  acw_pkg::acw_conv_t CONV;
  acw_pkg::acw_pin_t  SHARED_PIN;
  int                 failures, checked, i;

  acw_top uut (
    .MCLK(MCLK), .RST_B(RST_B), .S_AXI_AWADDR(S_AXI_AWADDR),
    .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID),
    .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
    .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR),
    .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
    .S_AXI_RREADY(S_AXI_RREADY), .CONV_DONE(CONV_DONE), .CONV_DATA(CONV_DATA),
    .CMP_OUT(CMP_OUT), .LVD_LOW(LVD_LOW), .PORT_CHANGE(PORT_CHANGE),
    .TIMER_SOURCE_SEL(TIMER_SOURCE_SEL), .CONV(CONV), .CONV_CLK(CONV_CLK),
    .SHARED_PIN(SHARED_PIN), .CONV_DONE_FLAG(CONV_DONE_FLAG),
    .COMPARATOR_FLAG(COMPARATOR_FLAG), .LOW_VOLT_FLAG(LOW_VOLT_FLAG), .WAKE_REQ(WAKE_REQ)
  );

  always #50 MCLK = ~MCLK;

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      failures++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask

  task automatic end_sim();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge MCLK);
  endtask

  // Address and data offered together; each released once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int   n;
    logic b;
    @(posedge MCLK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= {24'h0, d};
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    b = 1'b0;
    n = 0;
    while (!b && n < 60) begin
      @(posedge MCLK);
      n++;
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
      b = S_AXI_BVALID;
    end
    S_AXI_BREADY <= 1'b0;
    chk("wr_resp", {b, S_AXI_BRESP}, {1'b1, acw_pkg::RESP_OKAY});
  endtask

  task automatic rd(input logic [7:0] a);
    int   n;
    logic b;
    @(posedge MCLK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    b = 1'b0;
    n = 0;
    while (!b && n < 60) begin
      @(posedge MCLK);
      n++;
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
      b = S_AXI_RVALID;
    end
    S_AXI_RREADY <= 1'b0;
    rv = S_AXI_RDATA;
    rr = S_AXI_RRESP;
    chk("rd_done", b, 1'b1);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string nm);
    rd(a);
    chk(nm, rv, {24'h0, e});
  endtask

  // Period of the converter clock in MCLK cycles, second to third rise
  task automatic clkper(input logic [1:0] r, input int e);
    int   n, k, t0;
    logic p;
    wr(acw_pkg::A_CTL, {1'b0, r, 5'h08});
    p = CONV_CLK;
    k = 0;
    t0 = 0;
    for (n = 0; n < 120 && k < 3; n++) begin
      @(posedge MCLK);
      if (CONV_CLK && !p) k++;
      if (CONV_CLK && !p && k == 2) t0 = n;
      if (CONV_CLK && !p && k == 3) chk("clk_period", n - t0, e);
      p = CONV_CLK;
    end
    chk("clk_rises", k, 3);
  endtask

  // Plays the converter macro; mid tries a refused channel change while busy
  task automatic conv(input logic [11:0] raw, input bit mid);
    int n;
    wr(acw_pkg::A_CTL, 8'h1a);
    n = 0;
    while (!CONV.start && n < 40) begin
      @(posedge MCLK);
      n++;
    end
    chk("start", CONV.start, 1'b1);
    if (mid) wr(acw_pkg::A_CTL, 8'h0d);
    if (mid) rdc(acw_pkg::A_CTL, 8'h1a, "busy_ctl");
    @(posedge MCLK);
    CONV_DONE <= 1'b1;
    CONV_DATA <= raw;
    @(posedge MCLK);
    CONV_DONE <= 1'b0;
    CONV_DATA <= ~raw; // Result must be latched, not followed
    tick(2);
  endtask

  task automatic pulse_port();
    PORT_CHANGE <= 1'b1;
    @(posedge MCLK);
    PORT_CHANGE <= 1'b0;
    @(posedge MCLK);
  endtask

  initial begin
    #2000000;
    failures++;
    end_sim();
  end

  initial begin
    MCLK = 1'b0;
    RST_B = 1'b0;
    failures = 0;
    checked = 0;
    S_AXI_AWADDR = 8'h00;
    S_AXI_AWVALID = 1'b0;
    S_AXI_WDATA = 32'h0;
    S_AXI_WSTRB = 4'hf;
    S_AXI_WVALID = 1'b0;
    S_AXI_BREADY = 1'b0;
    S_AXI_ARADDR = 8'h00;
    S_AXI_ARVALID = 1'b0;
    S_AXI_RREADY = 1'b0;
    CONV_DONE = 1'b0;
    CONV_DATA = 12'h000;
    CMP_OUT = 1'b0;
    LVD_LOW = 1'b0;
    PORT_CHANGE = 1'b0;
    TIMER_SOURCE_SEL = 1'b0;
    tick(4);
    RST_B <= 1'b1;
    tick(3);
    rdc(acw_pkg::A_CTL, 8'h00, "ctl_rst");
    rdc(acw_pkg::A_OFS, 8'h00, "ofs_rst");
    rdc(acw_pkg::A_RHI, 8'h00, "res_rst");
    rdc(acw_pkg::A_STAT, 8'h00, "stat_nomask");
    rd(8'h1c);
    chk("bad_resp", {30'h0, rr}, {30'h0, acw_pkg::RESP_SLVERR});
    chk("bad_data", rv, 32'h0);
    wr(acw_pkg::A_MASK, 8'hff);
    rdc(acw_pkg::A_STAT, 8'h80, "stat_idle");
    for (i = 0; i < 4; i++) clkper(i[1:0], 16 >> i);
    wr(acw_pkg::A_CTL, 8'h00);
    tick(4);
    chk("clk_off", {CONV_CLK, CONV.power}, 2'b00);
    for (i = 0; i < 8; i++) begin
      wr(acw_pkg::A_CTL, i[7:0]);
      tick(2);
      chk("chan_ext", CONV.chan, i[3:0]);
    end
    wr(acw_pkg::A_OFS, 8'h01);
    wr(acw_pkg::A_CTL, 8'h04);
    tick(2);
    chk("chan_quarter", CONV.chan, 4'hc);
    wr(acw_pkg::A_CTL, 8'h00);
    tick(2);
    chk("chan_opamp", CONV.chan, 4'h8);
    for (i = 0; i < 4; i++) begin
      wr(acw_pkg::A_OFS, {5'h00, i[1:0], 1'b0});
      tick(2);
      chk("ref_level", {CONV.int_ref_on, CONV.int_ref_lvl}, {i != 0, i[1:0]});
    end
    tick(500);
    wr(acw_pkg::A_CTL, 8'h80);
    tick(2);
    chk("pin_ref", {SHARED_PIN, CONV.ref_ext}, 4'b1001);
    wr(acw_pkg::A_CTL, 8'h00);
    TIMER_SOURCE_SEL <= 1'b1;
    tick(3);
    chk("pin_timer", {SHARED_PIN, CONV.ref_ext}, 4'b0100);
    TIMER_SOURCE_SEL <= 1'b0;
    tick(3);
    chk("pin_port", SHARED_PIN, 3'b001);
    wr(acw_pkg::A_OFS, 8'h00);
    conv(12'h5a3, 1'b1);
    chk("done_flag", CONV_DONE_FLAG, 1'b1);
    rdc(acw_pkg::A_CTL, 8'h0a, "run_cleared");
    rdc(acw_pkg::A_RHI, 8'h5a, "res_hi");
    rdc(acw_pkg::A_RNIB, 8'h05, "res_nib");
    rdc(acw_pkg::A_RLO, 8'ha3, "res_lo");
    rdc(acw_pkg::A_STAT, 8'ha0, "stat_done");
    wr(acw_pkg::A_CTL, 8'h0d);
    tick(2);
    chk("chan_frozen", CONV.chan, 4'h2);
    wr(acw_pkg::A_STAT, 8'h00);
    wr(acw_pkg::A_STAT, 8'h70);
    rdc(acw_pkg::A_STAT, 8'h80, "flag_noset");
    wr(acw_pkg::A_CTL, 8'h0d);
    tick(2);
    chk("chan_free", CONV.chan, 4'h5);
    rdc(acw_pkg::A_RLO, 8'ha3, "res_held");
    wr(acw_pkg::A_OFS, 8'hd8);
    conv(12'h123, 1'b0);
    rdc(acw_pkg::A_RLO, 8'h29, "ofs_plus");
    wr(acw_pkg::A_OFS, 8'hb8);
    conv(12'habc, 1'b0);
    rdc(acw_pkg::A_RLO, 8'hae, "ofs_minus");
    wr(acw_pkg::A_OFS, 8'h78);
    conv(12'h100, 1'b0);
    rdc(acw_pkg::A_RNIB, 8'h01, "ofs_off");
    wr(acw_pkg::A_STAT, 8'h00);
    pulse_port();
    chk("wake_off", WAKE_REQ, 1'b0);
    wr(acw_pkg::A_STAT, 8'h02);
    pulse_port();
    chk("wake_port", WAKE_REQ, 1'b1);
    wr(acw_pkg::A_STAT, 8'h08);
    conv(12'h001, 1'b0);
    chk("wake_conv", WAKE_REQ, 1'b1);
    wr(acw_pkg::A_STAT, 8'h00);
    CMP_OUT <= 1'b1;
    tick(6);
    chk("cmp_flag", COMPARATOR_FLAG, 1'b1);
    rdc(acw_pkg::A_STAT, 8'h90, "stat_cmp");
    wr(acw_pkg::A_MASK, 8'hef);
    rdc(acw_pkg::A_STAT, 8'h80, "stat_masked");
    wr(acw_pkg::A_MASK, 8'hff);
    wr(acw_pkg::A_STAT, 8'h00);
    LVD_LOW <= 1'b1;
    tick(8);
    chk("lvd_flag", {LOW_VOLT_FLAG, COMPARATOR_FLAG}, 2'b10);
    rdc(acw_pkg::A_STAT, 8'h40, "lvd_low");
    LVD_LOW <= 1'b0;
    tick(8);
    wr(acw_pkg::A_STAT, 8'h00);
    rdc(acw_pkg::A_STAT, 8'h80, "lvd_ok");
    end_sim();
  end
endmodule

bind acw_top acw_props u_props (
  .MCLK(MCLK), .RST_B(RST_B), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
  .CONV_DONE(CONV_DONE), .PORT_CHANGE(PORT_CHANGE), .TIMER_SOURCE_SEL(TIMER_SOURCE_SEL),
  .CONV(CONV), .CONV_CLK(CONV_CLK), .SHARED_PIN(SHARED_PIN), .CONV_DONE_FLAG(CONV_DONE_FLAG),
  .COMPARATOR_FLAG(COMPARATOR_FLAG), .LOW_VOLT_FLAG(LOW_VOLT_FLAG), .WAKE_REQ(WAKE_REQ)
);
